// *** cbr_avmm_slave.sv ***
// Avalon-MM slave that turns bus cycles into register strobes with one wait cycle.
`default_nettype none
module cbr_avmm_slave (
    input  wire logic        ref_clk,          // 25 MHz clock.
    input  wire logic        rst_n,            // Asynchronous reset, active low.
    input  wire logic [7:0]  avs_address,      // Byte address.
    input  wire logic        avs_read,         // Read request.
    input  wire logic        avs_write,        // Write request.
    input  wire logic [31:0] avs_writedata,    // Write data.
    input  wire logic [3:0]  avs_byteenable,   // Byte lanes.
    output var  logic [31:0] avs_readdata,     // Registered read data.
    output wire logic        avs_waitrequest,  // Stall while high.
    cbr_bus_if.bus           rb                // Strobes to the bank.
);
    logic        ack_q;   // High in the cycle the request is answered.
    logic [31:0] rdat_q;  // Read data held for the answer.
    wire         req = avs_read | avs_write;

    // Every request waits exactly one cycle, then is answered.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req & ~ack_q;
        end
    end

    // Read data is captured in the wait cycle so it stands at the answer.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdat_q <= 32'h00000000;
        end else if (rb.rd_req) begin
            rdat_q <= rb.rdata;
        end
    end

    assign avs_waitrequest = req & ~ack_q;
    assign avs_readdata    = rdat_q;
    assign rb.wr_stb       = avs_write & ack_q;
    assign rb.rd_req       = avs_read & ~ack_q;
    assign rb.addr         = avs_address;
    assign rb.wdata        = avs_writedata;
    assign rb.be           = avs_byteenable;

    // A stalled request is answered on the next cycle.
    wait_one_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (req && avs_waitrequest) |=> !avs_waitrequest)
        else $error("request not answered after one wait cycle");
endmodule
`default_nettype wire

// *** cbr_bus_if.sv ***
// Internal register access strobes between the bus slave and the register bank.
`default_nettype none
interface cbr_bus_if;
    logic        wr_stb;  // Write takes effect this edge.
    logic        rd_req;  // Read data is captured this edge.
    logic [7:0]  addr;    // Byte address.
    logic [31:0] wdata;   // Write data.
    logic [3:0]  be;      // Byte enables.
    logic [31:0] rdata;   // Decoded read data.
    modport bus  (output wr_stb, rd_req, addr, wdata, be, input rdata);
    modport regs (input wr_stb, rd_req, addr, wdata, be, output rdata);
endinterface
`default_nettype wire

// *** cbr_config_rom_regs.sv ***
// Top of the configuration ROM header and bus information register bank.
// Bus access: each read or write sees waitrequest high for one cycle,
// then low; unmapped offsets read zero and ignore writes.
`default_nettype none
module cbr_config_rom_regs #(
    parameter int ADDR_W = 8  // Width of the Avalon byte address.
) (
    input  wire logic        ref_clk,          // 25 MHz clock.
    input  wire logic        rst_n,            // Asynchronous reset, active low.
    input  wire logic [7:0]  avs_address,      // Avalon byte address.
    input  wire logic        avs_read,         // Avalon read.
    input  wire logic        avs_write,        // Avalon write.
    input  wire logic [31:0] avs_writedata,    // Avalon write data.
    input  wire logic [3:0]  avs_byteenable,   // Avalon byte enables.
    output wire logic [31:0] avs_readdata,     // Avalon read data.
    output wire logic        avs_waitrequest,  // Avalon stall.
    input  wire logic        link_on_bit,      // Link enable from host control.
    input  wire logic        eeprom_present,   // Strap pin: EEPROM fitted.
    input  wire logic        eeprom_crc_valid, // Loader pulse, same clock.
    input  wire logic [15:0] eeprom_crc,       // Loaded check code.
    input  wire logic        rom_req,          // Remote quadlet read pulse.
    input  wire logic [47:0] rom_addr,         // Remote bus address.
    output wire logic        rom_ack,          // Remote answer pulse.
    output wire logic        rom_hit,          // Remote address matched.
    output wire logic [31:0] rom_data,         // Remote read data.
    output wire logic [7:0]  info_size,        // Header info size field.
    output wire logic [7:0]  crc_span,         // Header CRC span field.
    output wire logic [15:0] rom_check         // Header check code field.
);
    // The address decode compares eight bits of byte address.
    if (ADDR_W != 8) begin : g_bad_width
        $error("ADDR_W must be 8");
    end

    // Register access strobes from the bus slave.
    cbr_bus_if rb ();

    // Header register, bus options register and status flags.
    logic [31:0] hdr_q;        // Configuration ROM header.
    logic [31:0] hdr_d;        // Next header value.
    logic [31:0] opt_q;        // Bus options, read-only bits kept fixed.
    logic [31:0] opt_d;        // Next bus options value.
    logic        loaded_q;     // CRC was loaded from the EEPROM.
    logic        pres_m_q;     // First stage of the strap synchroniser.
    logic        pres_q;       // Synchronised EEPROM presence.
    logic        seen_q;       // A write has reached the header since reset.

    // Bus slave with one wait cycle per access.
    cbr_avmm_slave u_slave (
        .ref_clk         (ref_clk),
        .rst_n           (rst_n),
        .avs_address     (avs_address),
        .avs_read        (avs_read),
        .avs_write       (avs_write),
        .avs_writedata   (avs_writedata),
        .avs_byteenable  (avs_byteenable),
        .avs_readdata    (avs_readdata),
        .avs_waitrequest (avs_waitrequest),
        .rb              (rb.bus)
    );

    // Remote read port onto the same register values.
    cbr_rom_port u_rom (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .rom_req  (rom_req),
        .rom_addr (rom_addr),
        .hdr_val  (hdr_q),
        .opt_val  (opt_q),
        .rom_ack  (rom_ack),
        .rom_hit  (rom_hit),
        .rom_data (rom_data)
    );

    // Address decode.
    wire hit_hdr  = rb.addr == cbr_pkg::OFF_HDR;
    wire hit_bid  = rb.addr == cbr_pkg::OFF_BUSID;
    wire hit_opt  = rb.addr == cbr_pkg::OFF_OPT;
    wire hit_stat = rb.addr == cbr_pkg::OFF_STAT;

    // Byte lane mask from the byte enables.
    wire [31:0] be_mask = {{8{rb.be[3]}}, {8{rb.be[2]}},
                           {8{rb.be[1]}}, {8{rb.be[0]}}};

    // Write strobes; the identification and status words take no write.
    wire hdr_wr   = rb.wr_stb & hit_hdr;
    wire opt_wr   = rb.wr_stb & hit_opt;
    wire crc_load = pres_q & eeprom_crc_valid;

    // Header next value: host bytes first, then the EEPROM check code.
    // A host write in the same cycle as a load wins, as the later intent.
    wire [31:0] hdr_host = (hdr_q & ~be_mask) | (rb.wdata & be_mask);
    wire [31:0] hdr_load = {hdr_q[31:cbr_pkg::HDR_SPAN_LSB], eeprom_crc};

    assign hdr_d = hdr_wr   ? hdr_host :
                   crc_load ? hdr_load : hdr_q;

    // Only the writable option bits take host data.
    wire [31:0] opt_mask = be_mask & cbr_pkg::OPT_RW_MASK;
    assign opt_d = (opt_q & ~opt_mask) | (rb.wdata & opt_mask);

    // Status word shows the block's own state.
    wire [31:0] stat_w = {29'h00000000, pres_q, link_on_bit, loaded_q};

    // Read data selection; unmapped offsets read zero.
    assign rb.rdata = hit_hdr  ? hdr_q :
                      hit_bid  ? cbr_pkg::BUS_ID :
                      hit_opt  ? opt_q :
                      hit_stat ? stat_w : 32'h00000000;

    // Header fields as seen by the link layer.
    assign info_size = hdr_q[31:cbr_pkg::HDR_INFO_LSB];
    assign crc_span  = hdr_q[cbr_pkg::HDR_INFO_LSB-1:cbr_pkg::HDR_SPAN_LSB];
    assign rom_check = hdr_q[cbr_pkg::HDR_CRC_MSB:cbr_pkg::HDR_CRC_LSB];

    // Header register; the upper half comes out of reset as zero.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            hdr_q <= {cbr_pkg::HDR_UP_RST, cbr_pkg::HDR_CRC_RST};
        end else begin
            hdr_q <= hdr_d;
        end
    end

    // Bus options register with its read-only bits held at their values.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            opt_q <= cbr_pkg::OPT_RST;
        end else if (opt_wr) begin
            opt_q <= opt_d;
        end
    end

    // Two flip-flops bring the presence strap into the clock domain.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pres_m_q <= 1'b0;
            pres_q   <= 1'b0;
        end else begin
            pres_m_q <= eeprom_present;
            pres_q   <= pres_m_q;
        end
    end

    // Sticky flag: the check code came from the EEPROM.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            loaded_q <= 1'b0;
        end else if (crc_load) begin
            loaded_q <= 1'b1;
        end
    end

    // Helper for the reset check: set once the header is written.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            seen_q <= 1'b0;
        end else if (hdr_wr) begin
            seen_q <= 1'b1;
        end
    end

    // A full-word header write is read back as written.
    hdr_write_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (hdr_wr && rb.be == 4'hF) |=> hdr_q == $past(rb.wdata))
        else $error("header write not stored");

    // A load without a host write replaces only the check code.
    crc_load_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (crc_load && !hdr_wr) |=>
            (hdr_q[15:0] == $past(eeprom_crc) && hdr_q[31:16] == $past(hdr_q[31:16])
             && loaded_q))
        else $error("check code not loaded from EEPROM");

    // Until the host writes it, the header upper half stays zero.
    hdr_upper_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !seen_q |-> hdr_q[31:16] == 16'h0000)
        else $error("header upper half not zero after reset");

    // Reads of the identification word always return the constant.
    busid_read_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (avs_read && avs_address == 8'h1C) ##1 (avs_read && !avs_waitrequest)
            |-> avs_readdata == 32'h31333934)
        else $error("bus identification read wrong");

    // Read-only option bits keep their fixed values through any write.
    opt_ro_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        opt_wr |=> (opt_q & ~cbr_pkg::OPT_RW_MASK) == 32'h00000002)
        else $error("read-only option bits changed");

    // A header read returns the register as it stood when the read was taken.
    hdr_read_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (rb.rd_req && hit_hdr) |=> avs_readdata == $past(hdr_q))
        else $error("header read data wrong");

    // An options read returns the register as it stood when the read was taken.
    opt_read_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (rb.rd_req && hit_opt) |=> avs_readdata == $past(opt_q))
        else $error("bus options read data wrong");

    // The status word carries the three flags and zeros above them.
    stat_read_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (rb.rd_req && hit_stat) |=>
            avs_readdata == {29'h00000000, $past({pres_q, link_on_bit, loaded_q})})
        else $error("status read data wrong");

    // Offsets outside the bank read as zero.
    unmapped_zero_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (rb.rd_req && !(hit_hdr || hit_bid || hit_opt || hit_stat)) |=>
            avs_readdata == 32'h00000000)
        else $error("unmapped offset did not read zero");

    // The loaded flag stays set until the next reset.
    loaded_keep_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        loaded_q |=> loaded_q)
        else $error("loaded flag dropped");

    // Without a fitted EEPROM, only a host write may change the header.
    no_strap_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (!pres_q && !hdr_wr) |=> hdr_q == $past(hdr_q))
        else $error("header changed without a host write");

    // Writable option bits take the written data.
    opt_rw_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (opt_wr && rb.be == 4'hF) |=>
            (opt_q & 32'hF8FFF0C0) == ($past(rb.wdata) & 32'hF8FFF0C0))
        else $error("writable option bits not stored");
endmodule
`default_nettype wire

// *** cbr_pkg.sv ***
// Shared constants for the configuration ROM bus information register bank.
`default_nettype none
package cbr_pkg;
    // Host byte offsets of the registers.
    localparam logic [7:0]  OFF_HDR      = 8'h18;
    localparam logic [7:0]  OFF_BUSID    = 8'h1C;
    localparam logic [7:0]  OFF_OPT      = 8'h20;
    localparam logic [7:0]  OFF_STAT     = 8'h24;
    // Header field positions.
    localparam int          HDR_INFO_LSB = 24;
    localparam int          HDR_SPAN_LSB = 16;
    localparam int          HDR_CRC_MSB  = 15;
    localparam int          HDR_CRC_LSB  = 0;
    // Reset values; undefined header and option bits come up as zero.
    localparam logic [15:0] HDR_UP_RST   = 16'h0000;
    localparam logic [15:0] HDR_CRC_RST  = 16'h0000;
    localparam logic [31:0] BUS_ID       = 32'h31333934;
    localparam logic [31:0] OPT_RST      = 32'h0000A002;
    localparam logic [31:0] OPT_RW_MASK  = 32'hF8FFF0C0;
    localparam logic [31:0] OPT_RO_VAL   = 32'h00000002;
    // Status register bit positions.
    localparam int          ST_LOADED    = 0;
    localparam int          ST_LINK_ON   = 1;
    localparam int          ST_PRESENT   = 2;
    // Remote node addresses of the three quadlets.
    localparam logic [47:0] ROM_HDR      = 48'hFFFFF0000400;
    localparam logic [47:0] ROM_BUSID    = 48'hFFFFF0000404;
    localparam logic [47:0] ROM_OPT      = 48'hFFFFF0000408;
endpackage
`default_nettype wire

// *** cbr_rom_node_model.sv ***
// Remote bus node model that reads configuration ROM quadlets over the ROM port.
`default_nettype none
module cbr_rom_node_model (
    input  wire logic        ref_clk,   // Shared clock.
    input  wire logic        rom_ack,   // Answer pulse from the bank.
    input  wire logic        rom_hit,   // Address matched.
    input  wire logic [31:0] rom_data,  // Quadlet returned.
    output var  logic        rom_req,   // Read pulse to the bank.
    output var  logic [47:0] rom_addr   // Bus address of the quadlet.
);
    timeunit 1ns;
    timeprecision 1ps;
    // The node starts idle with no request pending.
    initial begin
        rom_req  = 1'b0;
        rom_addr = 48'h000000000000;
    end
    // One quadlet read: a single-cycle pulse, then the answer cycle is sampled.
    task automatic rd_quad(input logic [47:0] a, output logic ack, output logic hit,
                           output logic [31:0] d);
        rom_req  <= 1'b1;
        rom_addr <= a;
        @(posedge ref_clk);
        rom_req  <= 1'b0;
        // The released address is inverted so a stale value can never match.
        rom_addr <= ~a;
        // The answer stands in the cycle after the request edge and is taken at its end.
        @(posedge ref_clk);
        ack = rom_ack;
        hit = rom_hit;
        d   = rom_data;
    endtask
endmodule
`default_nettype wire

// *** cbr_rom_port.sv ***
// Remote node read port that serves the first three configuration ROM quadlets.
`default_nettype none
module cbr_rom_port (
    input  wire logic        ref_clk,   // 25 MHz clock.
    input  wire logic        rst_n,     // Asynchronous reset, active low.
    input  wire logic        rom_req,   // Quadlet read pulse.
    input  wire logic [47:0] rom_addr,  // Bus address of the quadlet.
    input  wire logic [31:0] hdr_val,   // Header register value.
    input  wire logic [31:0] opt_val,   // Bus options register value.
    output var  logic        rom_ack,   // Answer pulse.
    output var  logic        rom_hit,   // Address is one of ours.
    output var  logic [31:0] rom_data   // Quadlet read.
);
    wire         is_hdr = rom_addr == cbr_pkg::ROM_HDR;
    wire         is_bid = rom_addr == cbr_pkg::ROM_BUSID;
    wire         is_opt = rom_addr == cbr_pkg::ROM_OPT;
    wire [31:0]  sel    = is_hdr ? hdr_val :
                          is_bid ? cbr_pkg::BUS_ID :
                          is_opt ? opt_val : 32'h00000000;

    // The answer follows the request by one cycle; misses read as zero.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rom_ack  <= 1'b0;
            rom_hit  <= 1'b0;
            rom_data <= 32'h00000000;
        end else begin
            rom_ack  <= rom_req;
            rom_hit  <= rom_req & (is_hdr | is_bid | is_opt);
            if (rom_req) begin
                rom_data <= sel;
            end
        end
    end

    rom_hdr_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (rom_req && rom_addr == cbr_pkg::ROM_HDR) |=>
            (rom_ack && rom_hit && rom_data == $past(hdr_val)))
        else $error("header quadlet not served at its bus address");
    rom_busid_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (rom_req && rom_addr == cbr_pkg::ROM_BUSID) |=> rom_data == 32'h31333934)
        else $error("bus identification quadlet wrong");
    rom_opt_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (rom_req && rom_addr == cbr_pkg::ROM_OPT) |=> rom_data == $past(opt_val))
        else $error("bus options quadlet wrong");
endmodule
`default_nettype wire

// *** test_ieee1394_config_rom_bus_info_regs.sv ***
// Self-checking testbench for the configuration ROM bus information register bank.
`default_nettype none
module test_ieee1394_config_rom_bus_info_regs;
    timeunit 1ns;
    timeprecision 1ps;
    logic        ref_clk;          // 25 MHz clock.
    logic        rst_n;            // Active-low reset.
    logic [7:0]  avs_address;      // Register byte address.
    logic        avs_read;         // Read request.
    logic        avs_write;        // Write request.
    logic [31:0] avs_writedata;    // Write data.
    logic [3:0]  avs_byteenable;   // Byte lanes.
    logic [31:0] avs_readdata;     // Read data.
    logic        avs_waitrequest;  // Slave stall.
    logic        link_on_bit;      // Link enable level.
    logic        eeprom_present;   // EEPROM strap.
    logic        eeprom_crc_valid; // EEPROM load pulse.
    logic [15:0] eeprom_crc;       // EEPROM check code.
    logic        rom_req;          // Remote read pulse.
    logic [47:0] rom_addr;         // Remote address.
    logic        rom_ack;          // Remote answer.
    logic        rom_hit;          // Remote match.
    logic [31:0] rom_data;         // Remote data.
    logic [7:0]  info_size;        // Header info size field.
    logic [7:0]  crc_span;         // Header span field.
    logic [15:0] rom_check;        // Header check code field.
    int          n_errors;         // Mismatches seen.
    int          checks;           // Comparisons made.
    cbr_config_rom_regs DUT (.ref_clk(ref_clk), .rst_n(rst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .link_on_bit(link_on_bit),
        .eeprom_present(eeprom_present), .eeprom_crc_valid(eeprom_crc_valid),
        .eeprom_crc(eeprom_crc), .rom_req(rom_req), .rom_addr(rom_addr), .rom_ack(rom_ack),
        .rom_hit(rom_hit), .rom_data(rom_data), .info_size(info_size), .crc_span(crc_span),
        .rom_check(rom_check));
    cbr_rom_node_model node (.ref_clk(ref_clk), .rom_ack(rom_ack), .rom_hit(rom_hit),
        .rom_data(rom_data), .rom_req(rom_req), .rom_addr(rom_addr));
    // Free-running clock, 40 ns period.
    always #20 ref_clk = ~ref_clk;
    // Compare one value and report a mismatch at once.
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // One Avalon cycle: hold the request until waitrequest is seen low, then release.
    task automatic av_xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                           input logic [3:0] be, output logic [31:0] q);
        int n;
        n = 0;
        avs_address    <= a;
        avs_write      <= wr;
        avs_read       <= ~wr;
        avs_writedata  <= d;
        avs_byteenable <= be;
        // Sample at each rising edge; the edge that sees waitrequest low is the answer.
        do begin
            @(posedge ref_clk);
            n++;
        end while (avs_waitrequest !== 1'b0);
        chk("wait edges", n, 32'h00000002);
        q = avs_readdata;
        avs_read      <= 1'b0;
        avs_write     <= 1'b0;
        avs_address   <= ~a;
        avs_writedata <= ~d;
        @(posedge ref_clk);
    endtask
    // Register write with byte lanes.
    task automatic wr32(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
        logic [31:0] q;
        av_xfer(1'b1, a, d, be, q);
    endtask
    // Register read compared with an expected value.
    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        av_xfer(1'b0, a, 32'h00000000, 4'hF, q);
        chk(nm, q, exp);
    endtask
    // Hold reset for two edges, then release it on an edge.
    task automatic do_reset();
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
    endtask
    // One-cycle EEPROM load pulse, then two edges for the register to settle.
    task automatic pulse_crc(input logic [15:0] c);
        eeprom_crc       <= c;
        eeprom_crc_valid <= 1'b1;
        @(posedge ref_clk);
        eeprom_crc_valid <= 1'b0;
        repeat (2) @(posedge ref_clk);
    endtask
    // Values right after reset, and an unmapped offset.
    task automatic t_reset_vals();
        rd_chk("header", cbr_pkg::OFF_HDR, 32'h00000000);
        rd_chk("bus id", cbr_pkg::OFF_BUSID, 32'h31333934);
        rd_chk("options", cbr_pkg::OFF_OPT, 32'h0000A002);
        rd_chk("status", cbr_pkg::OFF_STAT, 32'h00000000);
        rd_chk("unmapped", 8'h28, 32'h00000000);
    endtask
    // Header fields, a single-lane write, then link on with a valid header.
    task automatic t_header();
        wr32(cbr_pkg::OFF_HDR, 32'h04A11234, 4'hF);
        rd_chk("header", cbr_pkg::OFF_HDR, 32'h04A11234);
        chk("info size", {24'h000000, info_size}, 32'h00000004);
        chk("crc span", {24'h000000, crc_span}, 32'h000000A1);
        chk("check", {16'h0000, rom_check}, 32'h00001234);
        wr32(cbr_pkg::OFF_HDR, 32'hFFFFFFFF, 4'h2);
        rd_chk("header lane", cbr_pkg::OFF_HDR, 32'h04A1FF34);
        link_on_bit <= 1'b1;
        @(posedge ref_clk);
        rd_chk("status", cbr_pkg::OFF_STAT, 32'h00000002);
    endtask
    // Writes to read-only places leave the returned values alone.
    task automatic t_readonly();
        wr32(cbr_pkg::OFF_BUSID, 32'h00000000, 4'hF);
        rd_chk("bus id", cbr_pkg::OFF_BUSID, 32'h31333934);
        wr32(cbr_pkg::OFF_OPT, 32'hFFFFFFFF, 4'hF);
        rd_chk("options ones", cbr_pkg::OFF_OPT, 32'hF8FFF0C2);
        wr32(cbr_pkg::OFF_OPT, 32'h00000000, 4'hF);
        rd_chk("options zero", cbr_pkg::OFF_OPT, 32'h00000002);
        wr32(8'h28, 32'hFFFFFFFF, 4'hF);
        rd_chk("unmapped", 8'h28, 32'h00000000);
    endtask
    // Remote reads of the three quadlets and of a neighbour that is not ours.
    task automatic t_rom();
        logic [47:0] ra [4] = '{48'hFFFFF0000400, 48'hFFFFF0000404, 48'hFFFFF0000408,
                                48'hFFFFF000040C};
        logic [31:0] re [4] = '{32'h04A1FF34, 32'h31333934, 32'h00000002, 32'h00000000};
        logic        ack;
        logic        hit;
        logic [31:0] d;
        for (int i = 0; i < 4; i++) begin
            node.rd_quad(ra[i], ack, hit, d);
            chk("rom ack", {31'h0, ack}, 32'h00000001);
            chk("rom hit", {31'h0, hit}, (i < 3) ? 32'h00000001 : 32'h00000000);
            chk("rom data", d, re[i]);
        end
    endtask
    // EEPROM load is ignored without the strap and taken with it.
    task automatic t_eeprom();
        pulse_crc(16'hABCD);
        chk("no eeprom", {16'h0000, rom_check}, 32'h0000FF34);
        eeprom_present <= 1'b1;
        repeat (3) @(posedge ref_clk);
        pulse_crc(16'h5AA5);
        rd_chk("eeprom crc", cbr_pkg::OFF_HDR, 32'h04A15AA5);
        rd_chk("status loaded", cbr_pkg::OFF_STAT, 32'h00000007);
    endtask
    // A reset in mid-run clears the header again.
    task automatic t_mid_reset();
        rst_n <= 1'b0;
        do_reset();
        rd_chk("header", cbr_pkg::OFF_HDR, 32'h00000000);
        chk("info size", {24'h000000, info_size}, 32'h00000000);
        rd_chk("options", cbr_pkg::OFF_OPT, 32'h0000A002);
        rd_chk("status", cbr_pkg::OFF_STAT, 32'h00000006);
    endtask
    // Verdict and end of run.
    task automatic end_sim();
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Main sequence: every input gets a value at time zero, then the scenarios run.
    initial begin
        n_errors = 0;
        checks = 0;
        ref_clk = 1'b0;
        rst_n = 1'b0;
        {avs_read, avs_write, link_on_bit, eeprom_present, eeprom_crc_valid} = 5'h00;
        avs_address = 8'h00;
        avs_writedata = 32'h00000000;
        avs_byteenable = 4'hF;
        eeprom_crc = 16'h0000;
        do_reset();
        t_reset_vals();
        t_header();
        t_readonly();
        t_rom();
        t_eeprom();
        t_mid_reset();
        end_sim();
    end
    // Watchdog: the run needs under a hundred cycles.
    initial begin
        repeat (3000) @(posedge ref_clk);
        n_errors++;
        end_sim();
    end
endmodule
`default_nettype wire
